// >>> core/sce_consts.svh
/*
  Offsets, reset values and timing counts of the state capture engine.
  Assumes inclusion by bare name from the core files.
*/
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH

// register byte offsets
`define SCE_OFS_CTRL    8'h00
`define SCE_OFS_CMD     8'h04
`define SCE_OFS_STATUS  8'h08
`define SCE_OFS_RUNLEN  8'h0C
`define SCE_OFS_STEPSZ  8'h10
`define SCE_OFS_POS     8'h14
`define SCE_OFS_DATA    8'h18
`define SCE_OFS_DMASK   8'h1C
`define SCE_OFS_TRIG    8'h20
`define SCE_OFS_LINES   8'h24
`define SCE_OFS_OPDIV   8'h28
`define SCE_OFS_RATIO   8'h2C

// control register fields
`define SCE_CTRL_INTCLK 0
`define SCE_CTRL_FALL   1
`define SCE_CTRL_OCLKEN 2
`define SCE_CTRL_OCLKIN 3
`define SCE_CTRL_TRIGEN 4
`define SCE_CTRL_UNSUP  5
`define SCE_CTRL_RST    6'h01

// command register fields
`define SCE_CMD_START   0
`define SCE_CMD_STOP    1
`define SCE_CMD_CONT    2
`define SCE_CMD_STEP    3
`define SCE_CMD_ABORT   4

// depth limits: 100 MSample, or 50 MSample when two bytes per sample
`define SCE_LIM_NARROW  27'h5F5E100
`define SCE_LIM_WIDE    27'h2FAF080

// timing
`define SCE_CLK_HZ      32'h02FAF080
`define SCE_REF_HZ      32'h0BEBC200
`define SCE_MIN_OP_HZ   32'h00000320
`define SCE_MAX_HALF    16'(`SCE_CLK_HZ / (32'h2 * `SCE_MIN_OP_HZ))
`define SCE_TRIG_DLY    3'h5

`define SCE_RESP_OKAY   2'h0
`define SCE_RESP_SLVERR 2'h2

`endif

// >>> core/sce_pkg.sv
/*
  Types of the state capture engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sce_pkg;
  typedef enum logic [2:0] {
    SCE_IDLE,
    SCE_WAIT_TRIG,
    SCE_DELAY,
    SCE_RUN,
    SCE_SUSP
  } sce_state_type;
endpackage

// >>> core/sce_clkgen.sv
/*
  Operating clock enables and the divided output clock.
  Assumes aclk at 50 MHz and an external clock pin synchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sce_consts.svh"
module sce_clkgen import sce_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // configuration
  input  wire logic        int_sel,
  input  wire logic [15:0] half_div,
  input  wire logic        ext_clk,
  input  wire logic        out_en,
  input  wire logic        out_inv,
  input  wire logic [15:0] out_ratio,
  // enables and pin
  output logic             op_rise,
  output logic             op_fall,
  output logic             out_clk
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        ph;
    logic        ext_q;
    logic        rise;
    logic        fall;
    logic [15:0] ocnt;
    logic        oclk;
    logic        pin;
  } sce_clk_state_type;

  sce_clk_state_type s_reg, s_next;
  logic [15:0]       hd;
  logic [15:0]       rat;

  always_comb begin
    s_next = s_reg;
    // lowest internal rate kept at or above 800 Hz
    hd = (half_div == 16'h0) ? 16'h1 : (half_div > `SCE_MAX_HALF ? `SCE_MAX_HALF : half_div);
    rat = (out_ratio == 16'h0) ? 16'h1 : out_ratio;
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    s_next.ext_q = ext_clk;
    if (int_sel) begin
      if (s_reg.cnt >= hd - 16'h1) begin
        s_next.cnt = 16'h0;
        s_next.ph = ~s_reg.ph;
        s_next.rise = ~s_reg.ph;
        s_next.fall = s_reg.ph;
      end else begin
        s_next.cnt = s_reg.cnt + 16'h1;
      end
    end else begin
      // external clock used undivided
      s_next.rise = ext_clk & ~s_reg.ext_q;
      s_next.fall = ~ext_clk & s_reg.ext_q;
    end
    // ratio half periods per output half period: ratio 1 mirrors the clock
    if (s_reg.rise | s_reg.fall) begin
      if (s_reg.ocnt >= rat - 16'h1) begin
        s_next.ocnt = 16'h0;
        s_next.oclk = ~s_reg.oclk;
      end else begin
        s_next.ocnt = s_reg.ocnt + 16'h1;
      end
    end
    s_next.pin = out_en & (s_next.oclk ^ out_inv);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign op_rise = s_reg.rise;
  assign op_fall = s_reg.fall;
  assign out_clk = s_reg.pin;

  a_edge_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(op_rise && op_fall)) else $error("rise and fall enables together");
endmodule
`default_nettype wire

// >>> core/sce_sampler.sv
/*
  Connector sampler: masks the lines and matches the trigger pattern.
  Assumes data pins synchronous to aclk and a one-cycle sample enable.
*/
`timescale 1ns/100ps
`default_nettype none
module sce_sampler import sce_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // sampling
  input  wire logic        tick,
  input  wire logic [15:0] data_in,
  input  wire logic [15:0] dmask,
  input  wire logic [15:0] tmask,
  input  wire logic [15:0] tval,
  // result
  output logic [15:0]      sample,
  output logic             sample_stb,
  output logic             trig_hit
);
  typedef struct packed {
    logic [15:0] q;
    logic        stb;
    logic        hit;
  } sce_smp_state_type;

  sce_smp_state_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.stb = tick;
    s_next.hit = 1'b0;
    if (tick) begin
      // line n lands on bit n, disabled lines read zero
      s_next.q = data_in & dmask;
      s_next.hit = ((data_in ^ tval) & tmask) == 16'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sample = s_reg.q;
  assign sample_stb = s_reg.stb;
  assign trig_hit = s_reg.hit;

  a_mask_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_stb |-> (sample & ~$past(dmask)) == 16'h0) else $error("disabled line set");
endmodule
`default_nettype wire

// >>> core/sce_top.sv
/*
  State capture engine: AXI4-Lite registers, job sequencing and
  control line drive. Assumes one 50 MHz clock and synchronous pins.
*/
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sce_consts.svh"
module sce_top import sce_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // connector
  input  wire logic [15:0] data_in,
  input  wire logic        ext_clk_in,
  output logic [5:0]       ctrl_out,
  output logic [5:0]       ctrl_oe_n,
  output logic             out_clk
);
  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic          aw_have;
    logic          w_have;
    logic [7:0]    waddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic [5:0]    ctrl;
    logic [26:0]   run_len;
    logic [26:0]   step_sz;
    logic [26:0]   job_len;
    logic [26:0]   pos;
    logic [26:0]   burst_left;
    logic [15:0]   dmask;
    logic [15:0]   tmask;
    logic [15:0]   tval;
    logic [5:0]    lvl;
    logic [5:0]    len;
    logic [15:0]   half_div;
    logic [15:0]   ratio;
    logic [15:0]   data_q;
    logic          data_v;
    logic          ovf;
    logic          done;
    logic          stepping;
    logic [2:0]    dly;
    logic [5:0]    ctrl_o;
    logic [5:0]    ctrl_oe_n;
    sce_state_type st;
  } sce_top_state_type;

  sce_top_state_type s_reg, s_next;
  logic              op_rise;
  logic              op_fall;
  logic [15:0]       sample;
  logic              sample_stb;
  logic              trig_hit;
  logic [4:0]        cmd;
  logic              wr_do;
  logic [31:0]       wm;
  logic [26:0]       lim;
  logic              popped;

  function automatic logic [31:0] sce_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [26:0] sce_clamp(input logic [26:0] v, input logic [26:0] hi);
    return (v == 27'h0) ? 27'h1 : ((v > hi) ? hi : v);
  endfunction

  sce_clkgen u_clkgen (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .int_sel   (s_reg.ctrl[`SCE_CTRL_INTCLK]),
    .half_div  (s_reg.half_div),
    .ext_clk   (ext_clk_in),
    .out_en    (s_reg.ctrl[`SCE_CTRL_OCLKEN]),
    .out_inv   (s_reg.ctrl[`SCE_CTRL_OCLKIN]),
    .out_ratio (s_reg.ratio),
    .op_rise   (op_rise),
    .op_fall   (op_fall),
    .out_clk   (out_clk)
  );

  sce_sampler u_sampler (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (s_reg.ctrl[`SCE_CTRL_FALL] ? op_fall : op_rise),
    .data_in    (data_in),
    .dmask      (s_reg.dmask),
    .tmask      (s_reg.tmask),
    .tval       (s_reg.tval),
    .sample     (sample),
    .sample_stb (sample_stb),
    .trig_hit   (trig_hit)
  );

  always_comb begin
    s_next = s_reg;
    popped = 1'b0;
    // two bytes per sample once any upper line is enabled
    lim = (|s_reg.dmask[15:8]) ? `SCE_LIM_WIDE : `SCE_LIM_NARROW;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.waddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    wr_do = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    wm = s_reg.wdata;
    cmd = 5'h0;
    if (wr_do) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `SCE_RESP_OKAY;
      unique case (s_reg.waddr)
        `SCE_OFS_CTRL: begin
          wm = sce_merge({26'h0, s_reg.ctrl}, s_reg.wdata, s_reg.wstrb);
          s_next.ctrl = wm[5:0];
        end
        `SCE_OFS_CMD: cmd = s_reg.wstrb[0] ? s_reg.wdata[4:0] : 5'h0;
        `SCE_OFS_RUNLEN: begin
          wm = sce_merge({5'h0, s_reg.run_len}, s_reg.wdata, s_reg.wstrb);
          s_next.run_len = wm[26:0];
        end
        `SCE_OFS_STEPSZ: begin
          wm = sce_merge({5'h0, s_reg.step_sz}, s_reg.wdata, s_reg.wstrb);
          s_next.step_sz = wm[26:0];
        end
        `SCE_OFS_DMASK: begin
          wm = sce_merge({16'h0, s_reg.dmask}, s_reg.wdata, s_reg.wstrb);
          s_next.dmask = wm[15:0];
        end
        `SCE_OFS_TRIG: begin
          wm = sce_merge({s_reg.tval, s_reg.tmask}, s_reg.wdata, s_reg.wstrb);
          s_next.tmask = wm[15:0];
          s_next.tval = wm[31:16];
        end
        `SCE_OFS_LINES: begin
          wm = sce_merge({18'h0, s_reg.len, 2'h0, s_reg.lvl}, s_reg.wdata, s_reg.wstrb);
          s_next.lvl = wm[5:0];
          s_next.len = wm[13:8];
        end
        `SCE_OFS_OPDIV: begin
          wm = sce_merge({16'h0, s_reg.half_div}, s_reg.wdata, s_reg.wstrb);
          s_next.half_div = wm[15:0];
        end
        `SCE_OFS_RATIO: begin
          wm = sce_merge({16'h0, s_reg.ratio}, s_reg.wdata, s_reg.wstrb);
          s_next.ratio = wm[15:0];
        end
        `SCE_OFS_STATUS, `SCE_OFS_POS, `SCE_OFS_DATA: s_next.bresp = `SCE_RESP_OKAY;
        default: s_next.bresp = `SCE_RESP_SLVERR;
      endcase
    end
    // read channel: answer one cycle after the address is taken
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `SCE_RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `SCE_OFS_CTRL:   s_next.rdata = {26'h0, s_reg.ctrl};
        `SCE_OFS_CMD:    s_next.rdata = 32'h0;
        `SCE_OFS_STATUS: s_next.rdata = {26'h0, s_reg.data_v, s_reg.done, s_reg.ovf, s_reg.st};
        `SCE_OFS_RUNLEN: s_next.rdata = {5'h0, s_reg.run_len};
        `SCE_OFS_STEPSZ: s_next.rdata = {5'h0, s_reg.step_sz};
        `SCE_OFS_POS:    s_next.rdata = {5'h0, s_reg.pos};
        `SCE_OFS_DATA: begin
          s_next.rdata = {16'h0, s_reg.data_q};
          popped = 1'b1;
        end
        `SCE_OFS_DMASK:  s_next.rdata = {16'h0, s_reg.dmask};
        `SCE_OFS_TRIG:   s_next.rdata = {s_reg.tval, s_reg.tmask};
        `SCE_OFS_LINES:  s_next.rdata = {18'h0, s_reg.len, 2'h0, s_reg.lvl};
        `SCE_OFS_OPDIV:  s_next.rdata = {16'h0, s_reg.half_div};
        `SCE_OFS_RATIO:  s_next.rdata = {16'h0, s_reg.ratio};
        default: begin
          s_next.rdata = 32'h0;
          s_next.rresp = `SCE_RESP_SLVERR;
        end
      endcase
    end
    if (popped) begin
      s_next.data_v = 1'b0;
    end
    // job sequencing
    unique case (s_reg.st)
      SCE_IDLE: begin
        if (cmd[`SCE_CMD_START] || cmd[`SCE_CMD_STEP]) begin
          s_next.ovf = 1'b0;
          s_next.done = 1'b0;
          s_next.data_v = 1'b0;
          s_next.pos = 27'h0;
          s_next.job_len = sce_clamp(s_reg.run_len, lim);
          s_next.stepping = !cmd[`SCE_CMD_START];
          s_next.burst_left = sce_clamp(s_reg.step_sz, sce_clamp(s_reg.run_len, lim));
          s_next.st = s_reg.ctrl[`SCE_CTRL_TRIGEN] ? SCE_WAIT_TRIG : SCE_RUN;
        end
      end
      SCE_WAIT_TRIG: begin
        if (trig_hit) begin
          s_next.dly = `SCE_TRIG_DLY;
          s_next.st = SCE_DELAY;
        end
      end
      SCE_DELAY: begin
        if (op_rise) begin
          s_next.dly = s_reg.dly - 3'h1;
          if (s_reg.dly == 3'h1) begin
            s_next.st = SCE_RUN;
          end
        end
      end
      SCE_RUN: begin
        if (sample_stb) begin
          if (s_reg.data_v && !popped) begin
            // unread word kept: it was captured before the fault
            s_next.ovf = 1'b1;
            s_next.st = SCE_IDLE;
          end else begin
            s_next.data_q = sample;
            s_next.data_v = 1'b1;
            s_next.pos = s_reg.pos + 27'h1;
            s_next.burst_left = s_reg.burst_left - 27'h1;
            if (s_reg.pos + 27'h1 == s_reg.job_len) begin
              s_next.done = 1'b1;
              s_next.st = SCE_IDLE;
            end else if (s_reg.stepping && s_reg.burst_left == 27'h1) begin
              s_next.st = SCE_SUSP;
            end
          end
        end else if (cmd[`SCE_CMD_STOP] && !s_reg.ctrl[`SCE_CTRL_UNSUP]) begin
          s_next.st = SCE_SUSP;
        end
      end
      SCE_SUSP: begin
        if (cmd[`SCE_CMD_CONT]) begin
          s_next.stepping = 1'b0;
          s_next.st = SCE_RUN;
        end else if (cmd[`SCE_CMD_STEP]) begin
          s_next.stepping = 1'b1;
          s_next.burst_left = sce_clamp(s_reg.step_sz, s_reg.job_len - s_reg.pos);
          s_next.st = SCE_RUN;
        end
      end
      default: s_next.st = SCE_IDLE;
    endcase
    if (cmd[`SCE_CMD_ABORT] && s_reg.st != SCE_IDLE) begin
      s_next.st = SCE_IDLE;
    end
    // lines float while idle, those set in len hold host levels during a job
    s_next.ctrl_o = s_reg.lvl;
    s_next.ctrl_oe_n = (s_next.st != SCE_IDLE) ? ~s_reg.len : 6'h3F;
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready = !s_next.w_have && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.ctrl <= `SCE_CTRL_RST;
      s_reg.ctrl_oe_n <= 6'h3F;
      s_reg.st <= SCE_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign ctrl_out = s_reg.ctrl_o;
  assign ctrl_oe_n = s_reg.ctrl_oe_n;

  default clocking sce_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pos_bound: assert property ((s_reg.st == SCE_RUN) |-> s_reg.pos < s_reg.job_len)
    else $error("position beyond run length");
  a_run_done: assert property ((s_reg.st == SCE_RUN && sample_stb && !s_reg.data_v
    && s_reg.pos + 27'h1 == s_reg.job_len) |=> s_reg.st == SCE_IDLE && s_reg.done)
    else $error("run did not finish at run length");
  a_trig_wait: assert property ((s_reg.st == SCE_WAIT_TRIG && trig_hit && cmd == 5'h0)
    |=> s_reg.st == SCE_DELAY && s_reg.dly == 3'h5) else $error("trigger delay not loaded");
  a_delay_end: assert property ((s_reg.st == SCE_DELAY && op_rise && s_reg.dly == 3'h1
    && cmd == 5'h0) |=> s_reg.st == SCE_RUN) else $error("delay did not end");
  a_idle_hold: assert property ((s_reg.st == SCE_IDLE && !cmd[0] && !cmd[3])
    |=> s_reg.st == SCE_IDLE) else $error("left idle without command");
  a_stop_susp: assert property ((s_reg.st == SCE_RUN && !sample_stb && cmd == 5'h2
    && !s_reg.ctrl[5]) |=> s_reg.st == SCE_SUSP) else $error("stop ignored");
  a_ovf_abort: assert property ((s_reg.st == SCE_RUN && sample_stb && s_reg.data_v
    && !popped) |=> s_reg.st == SCE_IDLE && s_reg.ovf && $stable(s_reg.data_q))
    else $error("overflow not handled");
  a_abort_idle: assert property ((cmd[4] && s_reg.st != SCE_IDLE) |=> s_reg.st == SCE_IDLE)
    else $error("abort ignored");
  a_ovf_sticky: assert property ((s_reg.ovf && s_reg.st == SCE_IDLE && !cmd[0] && !cmd[3])
    |=> s_reg.ovf) else $error("overflow flag lost");
  a_lines_hold: assert property ((s_reg.st != SCE_IDLE) ##1 (s_reg.st != SCE_IDLE)
    |-> ctrl_oe_n == ~$past(s_reg.len)) else $error("control lines not driven");
endmodule
`default_nettype wire

// >>> sim/sce_target.sv
/*
  Probed target model: connector levels and a gated external clock.
  Assumes the bench sets the levels and enables the clock between jobs.
*/
`timescale 1ns/100ps
`default_nettype none
module sce_target #(
  parameter int HALF = 40
) (
  // clock
  input  wire logic        aclk,
  // control from the bench
  input  wire logic [15:0] level,
  input  wire logic        ext_en,
  // target pins
  output logic [15:0]      data_in,
  output logic             ext_clk_in
);
  int cnt = 0;

  // lines flip while the clock is high, so the sampling edge shows in the data
  assign data_in = level ^ {16{ext_clk_in}};

  // clock stands still while gated, so no stray edge reaches the core
  always @(posedge aclk) begin
    if (!ext_en) begin
      cnt <= 0;
      ext_clk_in <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_clk_in <= ~ext_clk_in;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/state_capture_engine_test.sv
/*
  Self-checking bench of the state capture engine over AXI4-Lite.
  Assumes the core files and the target model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sce_consts.svh"
module state_capture_engine_test;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ext_clk_in, ext_en, out_clk;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, br, rr;
  logic [15:0] data_in, level;
  logic [5:0]  ctrl_out, ctrl_oe_n;
  int          fails, comparisons, cyc;

  sce_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .data_in(data_in), .ext_clk_in(ext_clk_in), .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n),
    .out_clk(out_clk)
  );

  sce_target target (.aclk(aclk), .level(level), .ext_en(ext_en), .data_in(data_in),
    .ext_clk_in(ext_clk_in));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // whole run needs a few thousand cycles; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    forever begin
      @(posedge aclk);
      if (aw && awready) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
      if (bvalid) begin
        br = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] v);
    for (int n = 0; n < 400; n++) begin
      rd(`SCE_OFS_STATUS);
      if ((rv & m) === v) break;
    end
    chk("status", rv & m, v);
  endtask

  task automatic get(input logic [15:0] e);
    st(32'h20, 32'h20);
    rd(`SCE_OFS_DATA);
    chk("data", rv, {16'h0, e});
  endtask

  task automatic pos(input logic [31:0] e);
    rd(`SCE_OFS_POS);
    chk("pos", rv, e);
  endtask

  task automatic t_reset;
    rd(`SCE_OFS_CTRL);
    chk("ctrl", rv, 32'h1);
    st(32'h3F, 32'h0);
    chk("oe", ctrl_oe_n, 6'h3F);
    rd(8'h30);
    chk("rresp", rr, 2'h2);
    chk("rdata", rv, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    chk("bresp", br, 2'h2);
    wr(`SCE_OFS_POS, 32'h55);
    chk("bresp ro", br, 2'h0);
    pos(32'h0);
    wstrb <= 4'h2;
    wr(`SCE_OFS_DMASK, 32'h0000AB12);
    wstrb <= 4'hF;
    rd(`SCE_OFS_DMASK);
    chk("strobe", rv, 32'hAB00);
  endtask

  task automatic t_run;
    wr(`SCE_OFS_LINES, 32'h0D2A);
    wr(`SCE_OFS_DMASK, 32'h00F5);
    wr(`SCE_OFS_OPDIV, 32'h28);
    wr(`SCE_OFS_RUNLEN, 32'h3);
    level <= 16'hA5A5;
    chk("ctrl_out", ctrl_out, 6'h2A);
    wr(`SCE_OFS_CMD, 32'h1);
    st(32'h7, 32'h3);
    chk("oe run", ctrl_oe_n, 6'h32);
    repeat (3) get(16'h00A5);
    st(32'h17, 32'h10);
    pos(32'h3);
    chk("oe idle", ctrl_oe_n, 6'h3F);
  endtask

  task automatic t_edge;
    // asymmetric pattern: a reversed line order would show
    level <= 16'h8003;
    wr(`SCE_OFS_DMASK, 32'hFFFF);
    wr(`SCE_OFS_RUNLEN, 32'h2);
    ext_en <= 1'b1;
    // external clock, falling-edge sampling
    wr(`SCE_OFS_CTRL, 32'h2);
    wr(`SCE_OFS_CMD, 32'h1);
    get(16'h8003);
    get(16'h8003);
    st(32'h17, 32'h10);
    wr(`SCE_OFS_CTRL, 32'h1);
    ext_en <= 1'b0;
    level <= 16'h8001;
  endtask

  task automatic t_ovf;
    wr(`SCE_OFS_OPDIV, 32'h1);
    wr(`SCE_OFS_RUNLEN, 32'hA);
    wr(`SCE_OFS_CMD, 32'h1);
    st(32'h0F, 32'h08);
    pos(32'h1);
    rd(`SCE_OFS_DATA);
    chk("kept", rv, 32'h8001);
    wr(`SCE_OFS_OPDIV, 32'h28);
    wr(`SCE_OFS_CMD, 32'h1);
    st(32'h0F, 32'h03);
    wr(`SCE_OFS_CMD, 32'h10);
    st(32'h07, 32'h0);
  endtask

  task automatic t_susp;
    wr(`SCE_OFS_RUNLEN, 32'h4);
    wr(`SCE_OFS_CMD, 32'h1);
    for (int i = 1; i < 3; i++) begin
      get(16'h8001);
      wr(`SCE_OFS_CMD, 32'h2);
      st(32'h7, 32'h4);
      pos(i);
      wr(`SCE_OFS_CMD, 32'h4);
      st(32'h7, 32'h3);
    end
    repeat (2) get(16'h8001);
    st(32'h17, 32'h10);
    pos(32'h4);
  endtask

  task automatic t_step;
    wr(`SCE_OFS_STEPSZ, 32'h2);
    wr(`SCE_OFS_RUNLEN, 32'h5);
    for (int i = 1; i < 4; i++) begin
      wr(`SCE_OFS_CMD, 32'h8);
      repeat (i < 3 ? 2 : 1) get(16'h8001);
      st(32'h7, i < 3 ? 32'h4 : 32'h0);
      pos(i < 3 ? 2 * i : 5);
    end
  endtask

  task automatic t_unsup;
    // host never suspends: it only reads data and checks status at the end
    wr(`SCE_OFS_CTRL, 32'h21);
    wr(`SCE_OFS_RUNLEN, 32'h2);
    wr(`SCE_OFS_CMD, 32'h1);
    repeat (2) get(16'h8001);
    st(32'h1F, 32'h10);
    pos(32'h2);
    wr(`SCE_OFS_CTRL, 32'h1);
  endtask

  task automatic t_trig;
    level <= 16'h0000;
    wr(`SCE_OFS_TRIG, 32'h00A500FF);
    wr(`SCE_OFS_CTRL, 32'h11);
    wr(`SCE_OFS_RUNLEN, 32'h1);
    wr(`SCE_OFS_CMD, 32'h1);
    st(32'h7, 32'h1);
    level <= 16'h12A5;
    get(16'h12A5);
    st(32'h17, 32'h10);
    wr(`SCE_OFS_CTRL, 32'h1);
  endtask

  task automatic t_oclk;
    time t0;
    wr(`SCE_OFS_OPDIV, 32'h2);
    // ratio 0 behaves as 1; first period after a change may be short
    for (int r = 0; r < 4; r++) begin
      wr(`SCE_OFS_RATIO, r);
      wr(`SCE_OFS_CTRL, 32'h5);
      repeat (2) @(posedge out_clk);
      t0 = $time;
      @(posedge out_clk);
      chk("oclk", 32'(($time - t0) / 20), 32'(4 * (r == 0 ? 1 : r)));
    end
    wr(`SCE_OFS_CTRL, 32'h1);
    // pin follows the enable one cycle after the write lands
    repeat (2) @(posedge aclk);
    chk("oclk off", out_clk, 1'b0);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ext_en} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    level = '0;
    fails = 0;
    comparisons = 0;
    cyc = 0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_run;
    t_edge;
    t_ovf;
    t_susp;
    t_step;
    t_unsup;
    t_trig;
    t_oclk;
    test_done;
  end
endmodule
`default_nettype wire
